// file: psag_pkg.sv
// constants and types for the program space address generator
package psag_pkg;
	localparam int PA_W   = 24;
	localparam int DW     = 16;
	localparam int PAGE_W = 8;
	localparam int IDX_W  = 4;
	localparam int CFG_BIT = 7;
	localparam int REMAP_EN_BIT = 2;
	localparam int REG_AW = 4;
	localparam logic [3:0] ADDR_TABLE_PAGE = 4'h0;
	localparam logic [3:0] ADDR_VIS_PAGE   = 4'h1;
	localparam logic [3:0] ADDR_CORE_CTRL  = 4'h2;
	localparam logic [3:0] ADDR_STATUS     = 4'h3;
	localparam logic [7:0] TABLE_PAGE_RST  = 8'h00;
	localparam logic [7:0] VIS_PAGE_RST    = 8'h00;
	localparam logic [15:0] CORE_CTRL_RST  = 16'h0000;
	typedef enum logic [1:0] {
		PSAG_FETCH,
		PSAG_TABLE,
		PSAG_DATA
	} psag_access_t;
	typedef enum logic [1:0] {
		PSAG_TBL_READ_LOW,
		PSAG_TBL_READ_HIGH,
		PSAG_TBL_WRITE_LOW,
		PSAG_TBL_WRITE_HIGH
	} psag_tbl_op_t;
endpackage

// file: psag_top.sv
// program space address generation, table read data steering and bit reversal
`timescale 1ns/1ps
//
// Contract
// R1: mirror the 4-bit index bits to give the bit-reversed entry.
// R2: program words are 24 bits, data words 16 bits.
// R3: table address is table_page above the full 16-bit effective address.
// R4: table_page bit 7 picks user (0) or configuration (1) space.
// R5: remap address is visibility_page joined above effective address bits 14..0.
// R6: remap path forces program address bit 23 to zero.
// R7: remap program address bit 15 comes from visibility_page bit 0.
// R8: remap and fetch addresses have bit 0 forced to zero.
// R9: table accesses take unaligned addresses and may reach configuration space.
// R10: low read, word mode returns program bits 15..0.
// R11: low read, byte mode returns upper byte if select is 1, else lower.
// R12: high read, word mode returns bits 23..16 with zero upper byte.
// R13: high read, byte mode, select 1 returns zero phantom byte.
// R14: program counter advances by two per program word.
// R15: low table ops touch bits 15..0; high ones touch only bits 23..16.
// R16: remapped space is read-only and shows only the low word.
// R17: table page spans 32K words, visibility page 16K words.
// R18: remap only when address bit 15 and remap_enable are both set.
// R19: remap suppressed while a table read or write is in progress.
// R20: address source chosen by access type; byte select is address bit 0.
module psag_top (
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic [3:0]           reg_addr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [15:0]          reg_rdata,
	input  wire logic                 acc_valid,
	input  wire psag_pkg::psag_access_t acc_type,
	input  wire psag_pkg::psag_tbl_op_t tbl_op,
	input  wire logic                 tbl_byte_mode,
	input  wire logic [15:0]          eff_addr,
	input  wire logic [15:0]          tbl_wdata,
	input  wire logic [22:0]          pc,
	input  wire logic [3:0]           rev_index,
	input  wire logic [23:0]          pm_rdata,
	output logic                      pm_rd,
	output logic                      pm_wr,
	output logic      [23:0]          pm_addr,
	output logic      [23:0]          pm_wdata,
	output logic      [2:0]           pm_wmask,
	output logic                      pm_cfg_space,
	output logic                      rd_valid,
	output logic      [15:0]          rd_data,
	output logic      [3:0]           rev_out,
	output logic                      remap_denied
);
	logic [7:0]  table_page_r;
	logic [7:0]  visibility_page_r;
	logic [15:0] core_control_r;
	logic        remap_enable;
	logic        tbl_busy_r;
	// low-order select and read kind held for steering next cycle's returned word
	logic        sel_byte_r;
	logic        byte_mode_r;
	psag_pkg::psag_tbl_op_t op_r;
	logic        is_table_rd_r;
	logic        rd_pend_r;
	logic        is_remap;
	logic        is_table;
	logic        is_fetch;
	logic [23:0] addr_nxt;
	logic [15:0] steer_nxt;
	logic        tbl_write;

	assign remap_enable = core_control_r[psag_pkg::REMAP_EN_BIT];
	assign is_table = acc_valid && acc_type == psag_pkg::PSAG_TABLE;
	assign is_fetch = acc_valid && acc_type == psag_pkg::PSAG_FETCH;
	// table activity blocks visibility so the two never fight for the array
	assign is_remap = acc_valid && acc_type == psag_pkg::PSAG_DATA && eff_addr[15]
		&& remap_enable && !tbl_busy_r && !is_table; // [R18] [R19]
	assign tbl_write = is_table && (tbl_op == psag_pkg::PSAG_TBL_WRITE_LOW
		|| tbl_op == psag_pkg::PSAG_TBL_WRITE_HIGH);

	// register file
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			table_page_r      <= psag_pkg::TABLE_PAGE_RST;
			visibility_page_r <= psag_pkg::VIS_PAGE_RST;
			core_control_r    <= psag_pkg::CORE_CTRL_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				psag_pkg::ADDR_TABLE_PAGE: table_page_r <= reg_wdata[7:0];
				psag_pkg::ADDR_VIS_PAGE: visibility_page_r <= reg_wdata[7:0];
				psag_pkg::ADDR_CORE_CTRL: core_control_r <= reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				psag_pkg::ADDR_TABLE_PAGE: reg_rdata <= {8'h00, table_page_r};
				psag_pkg::ADDR_VIS_PAGE: reg_rdata <= {8'h00, visibility_page_r};
				psag_pkg::ADDR_CORE_CTRL: reg_rdata <= core_control_r;
				psag_pkg::ADDR_STATUS: reg_rdata <= {13'h0000, remap_enable,
					tbl_busy_r, rd_pend_r};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// program address selection
	always_comb begin
		addr_nxt = 24'h000000;
		if (is_table) begin
			// full byte address, unaligned allowed; page spans 32K words
			addr_nxt = {table_page_r, eff_addr}; // [R3] [R9] [R17] [R20]
		end else if (is_remap) begin
			// eff_addr[15] is dropped; page spans 16K words
			addr_nxt = {1'b0, visibility_page_r, eff_addr[14:1], 1'b0}; // [R5] [R6] [R7] [R8] [R17]
		end else if (is_fetch) begin
			// pc counts in steps of two per 24-bit word
			addr_nxt = {1'b0, pc[22:1], 1'b0}; // [R8] [R14]
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pm_addr      <= 24'h000000;
			pm_rd        <= 1'b0;
			pm_wr        <= 1'b0;
			pm_wdata     <= 24'h000000;
			pm_wmask     <= 3'h0;
			pm_cfg_space <= 1'b0;
		end else begin
			pm_addr      <= addr_nxt;
			pm_rd        <= is_fetch || is_remap || (is_table && !tbl_write);
			// remapped path never writes
			pm_wr        <= tbl_write; // [R16]
			pm_cfg_space <= is_table && table_page_r[psag_pkg::CFG_BIT]; // [R4]
			pm_wdata     <= 24'h000000;
			pm_wmask     <= 3'h0;
			if (tbl_write) begin
				if (tbl_op == psag_pkg::PSAG_TBL_WRITE_LOW) begin
					pm_wdata <= {8'h00, tbl_wdata}; // [R15]
					if (!tbl_byte_mode)
						pm_wmask <= 3'h3;
					else if (eff_addr[0])
						pm_wmask <= 3'h2;
					else
						pm_wmask <= 3'h1;
				end else begin
					// high byte only; phantom byte write has no target
					pm_wdata <= {tbl_wdata[7:0], 16'h0000}; // [R15]
					pm_wmask <= (tbl_byte_mode && eff_addr[0]) ? 3'h0 : 3'h4;
				end
			end
		end
	end

	// table in flight flag: one cycle after a table access is issued
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tbl_busy_r    <= 1'b0;
			rd_pend_r     <= 1'b0;
			is_table_rd_r <= 1'b0;
			sel_byte_r    <= 1'b0;
			byte_mode_r   <= 1'b0;
			op_r          <= psag_pkg::PSAG_TBL_READ_LOW;
			remap_denied  <= 1'b0;
		end else begin
			tbl_busy_r    <= is_table;
			rd_pend_r     <= (is_table && !tbl_write) || is_remap;
			is_table_rd_r <= is_table && !tbl_write;
			sel_byte_r    <= eff_addr[0]; // [R20]
			byte_mode_r   <= tbl_byte_mode;
			op_r          <= tbl_op;
			remap_denied  <= acc_valid && acc_type == psag_pkg::PSAG_DATA
				&& eff_addr[15] && remap_enable && !is_remap; // [R19]
		end
	end

	// steering of the 24-bit word returned onto the 16-bit data side
	always_comb begin
		steer_nxt = pm_rdata[15:0]; // [R2] [R16]
		if (is_table_rd_r) begin
			if (op_r == psag_pkg::PSAG_TBL_READ_HIGH) begin
				if (!byte_mode_r)
					steer_nxt = {8'h00, pm_rdata[23:16]}; // [R12]
				else if (sel_byte_r)
					steer_nxt = 16'h0000; // [R13]
				else
					steer_nxt = {8'h00, pm_rdata[23:16]}; // [R15]
			end else begin
				if (!byte_mode_r)
					steer_nxt = pm_rdata[15:0]; // [R10]
				else if (sel_byte_r)
					steer_nxt = {8'h00, pm_rdata[15:8]}; // [R11]
				else
					steer_nxt = {8'h00, pm_rdata[7:0]}; // [R11]
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid <= 1'b0;
			rd_data  <= 16'h0000;
		end else begin
			rd_valid <= rd_pend_r;
			rd_data  <= rd_pend_r ? steer_nxt : 16'h0000;
		end
	end

	// bit reversal of the index
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			rev_out <= 4'h0;
		else
			rev_out <= {rev_index[0], rev_index[1], rev_index[2], rev_index[3]}; // [R1]
	end

	a_rev_mirror: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1 |=> rev_out == {$past(rev_index[0]), $past(rev_index[1]),
			$past(rev_index[2]), $past(rev_index[3])}) // [R1]
		else $error("bit reversal wrong");
	a_table_addr: assert property (@(posedge clock) disable iff (!rst_n)
		is_table |=> pm_addr == {$past(table_page_r), $past(eff_addr)}) // [R3]
		else $error("table address wrong");
	a_cfg_space: assert property (@(posedge clock) disable iff (!rst_n)
		is_table |=> pm_cfg_space == $past(table_page_r[7])) // [R4]
		else $error("config space select wrong");
	a_remap_addr: assert property (@(posedge clock) disable iff (!rst_n)
		is_remap |=> pm_addr[23] == 1'b0 && pm_addr[0] == 1'b0
			&& pm_addr[22:15] == $past(visibility_page_r)
			&& pm_addr[14:1] == $past(eff_addr[14:1])) // [R5]
		else $error("remap address wrong");
	a_remap_gate: assert property (@(posedge clock) disable iff (!rst_n)
		(acc_valid && acc_type == psag_pkg::PSAG_DATA && (!eff_addr[15] || !remap_enable))
			|=> !pm_rd) // [R18]
		else $error("remap without enable");
	a_remap_block: assert property (@(posedge clock) disable iff (!rst_n)
		tbl_busy_r |-> !is_remap) // [R19]
		else $error("remap during table op");
	a_fetch_align: assert property (@(posedge clock) disable iff (!rst_n)
		is_fetch |=> pm_addr[0] == 1'b0 && pm_addr[22:1] == $past(pc[22:1])) // [R8]
		else $error("fetch address wrong");
	a_phantom_zero: assert property (@(posedge clock) disable iff (!rst_n)
		(is_table && tbl_op == psag_pkg::PSAG_TBL_READ_HIGH && tbl_byte_mode && eff_addr[0])
			|-> ##2 rd_valid && rd_data == 16'h0000) // [R13]
		else $error("phantom byte not zero");
	a_high_word: assert property (@(posedge clock) disable iff (!rst_n)
		(is_table && tbl_op == psag_pkg::PSAG_TBL_READ_HIGH && !tbl_byte_mode)
			|-> ##2 rd_data[15:8] == 8'h00) // [R12]
		else $error("high word upper byte nonzero");
	a_remap_ro: assert property (@(posedge clock) disable iff (!rst_n)
		is_remap |=> !pm_wr) // [R16]
		else $error("remap wrote");

	// address formation per access type

	a_cfg_user: assert property (@(posedge clock) disable iff (!rst_n)
		(is_table && !table_page_r[psag_pkg::CFG_BIT]) |=> !pm_cfg_space) // [R4]
		else $error("user table access marked config");

	a_remap_user: assert property (@(posedge clock) disable iff (!rst_n)
		is_remap |=> !pm_cfg_space && pm_addr[23] == 1'b0) // [R6]
		else $error("remap left user space");

	a_remap_bit15: assert property (@(posedge clock) disable iff (!rst_n)
		is_remap |=> pm_addr[15] == $past(visibility_page_r[0])) // [R7]
		else $error("remap bit 15 not from page");

	a_remap_align: assert property (@(posedge clock) disable iff (!rst_n)
		is_remap |=> pm_addr[0] == 1'b0) // [R8]
		else $error("remap address unaligned");

	a_table_unalign: assert property (@(posedge clock) disable iff (!rst_n)
		is_table |=> pm_addr[0] == $past(eff_addr[0])) // [R9]
		else $error("table byte address altered");

	a_table_span: assert property (@(posedge clock) disable iff (!rst_n)
		is_table |=> pm_addr[23:16] == $past(table_page_r)) // [R17]
		else $error("table page span wrong");

	a_fetch_user: assert property (@(posedge clock) disable iff (!rst_n)
		is_fetch |=> pm_addr[23] == 1'b0 && !pm_cfg_space) // [R14]
		else $error("fetch left user space");

	a_fetch_read: assert property (@(posedge clock) disable iff (!rst_n)
		is_fetch |=> pm_rd && !pm_wr) // [R20]
		else $error("fetch not a read");

	a_table_read: assert property (@(posedge clock) disable iff (!rst_n)
		(is_table && !tbl_write) |=> pm_rd && !pm_wr) // [R20]
		else $error("table read not a read");

	// read data steering, two cycles after the access

	a_low_word: assert property (@(posedge clock) disable iff (!rst_n)
		(is_table && tbl_op == psag_pkg::PSAG_TBL_READ_LOW && !tbl_byte_mode)
			|-> ##2 rd_valid && rd_data == $past(pm_rdata[15:0])) // [R10]
		else $error("low word read wrong");

	a_low_upper: assert property (@(posedge clock) disable iff (!rst_n)
		(is_table && tbl_op == psag_pkg::PSAG_TBL_READ_LOW && tbl_byte_mode && eff_addr[0])
			|-> ##2 rd_data == {8'h00, $past(pm_rdata[15:8])}) // [R11]
		else $error("low upper byte wrong");

	a_low_lower: assert property (@(posedge clock) disable iff (!rst_n)
		(is_table && tbl_op == psag_pkg::PSAG_TBL_READ_LOW && tbl_byte_mode && !eff_addr[0])
			|-> ##2 rd_data == {8'h00, $past(pm_rdata[7:0])}) // [R11]
		else $error("low lower byte wrong");

	a_high_data: assert property (@(posedge clock) disable iff (!rst_n)
		(is_table && tbl_op == psag_pkg::PSAG_TBL_READ_HIGH && !tbl_byte_mode)
			|-> ##2 rd_data[7:0] == $past(pm_rdata[23:16])) // [R12]
		else $error("high word data wrong");

	a_high_byte: assert property (@(posedge clock) disable iff (!rst_n)
		(is_table && tbl_op == psag_pkg::PSAG_TBL_READ_HIGH && tbl_byte_mode && !eff_addr[0])
			|-> ##2 rd_data == {8'h00, $past(pm_rdata[23:16])}) // [R15]
		else $error("high byte read wrong");

	a_remap_low: assert property (@(posedge clock) disable iff (!rst_n)
		is_remap |-> ##2 rd_valid && rd_data == $past(pm_rdata[15:0])) // [R16]
		else $error("remap data not low word");

	a_rd_pulse: assert property (@(posedge clock) disable iff (!rst_n)
		!rd_pend_r |=> !rd_valid && rd_data == 16'h0000) // [R2]
		else $error("read data outside its cycle");

	// write lanes

	a_wr_low_lanes: assert property (@(posedge clock) disable iff (!rst_n)
		(is_table && tbl_op == psag_pkg::PSAG_TBL_WRITE_LOW) |=> pm_wr && !pm_wmask[2]) // [R15]
		else $error("low write touched high byte");

	a_wr_lo_sel: assert property (@(posedge clock) disable iff (!rst_n)
		(is_table && tbl_op == psag_pkg::PSAG_TBL_WRITE_LOW && tbl_byte_mode && !eff_addr[0])
			|=> pm_wmask == 3'h1) // [R15]
		else $error("low byte write lane wrong");

	a_wr_hi_sel: assert property (@(posedge clock) disable iff (!rst_n)
		(is_table && tbl_op == psag_pkg::PSAG_TBL_WRITE_LOW && tbl_byte_mode && eff_addr[0])
			|=> pm_wmask == 3'h2) // [R15]
		else $error("upper byte write lane wrong");

	a_wr_high_lanes: assert property (@(posedge clock) disable iff (!rst_n)
		(is_table && tbl_op == psag_pkg::PSAG_TBL_WRITE_HIGH) |=> pm_wr && pm_wmask[1:0] == 2'h0) // [R15]
		else $error("high write touched low word");

	a_wr_high_data: assert property (@(posedge clock) disable iff (!rst_n)
		(is_table && tbl_op == psag_pkg::PSAG_TBL_WRITE_HIGH)
			|=> pm_wdata[23:16] == $past(tbl_wdata[7:0])) // [R15]
		else $error("high write data wrong");

	// a refused remap never reaches the array
	a_denied_idle: assert property (@(posedge clock) disable iff (!rst_n)
		remap_denied |-> !pm_rd) // [R19]
		else $error("denied remap still read");
endmodule

// file: psag_pm_model.sv
// program memory model answering reads in the cycle of the read strobe
`timescale 1ns/1ps
module psag_pm_model (
	input  wire logic        clock,
	input  wire logic        pm_rd,
	input  wire logic [23:0] pm_addr,
	output logic      [23:0] pm_rdata
);
	logic [23:0] last_r;

	// content follows address bits 15..0 so that each location within one 64K span differs
	function automatic logic [23:0] psag_word(input logic [23:0] a);
		return {a[7:0] ^ 8'h5A, a[15:0] ^ 16'hC3C3};
	endfunction

	initial last_r = 24'h000000;
	// idle bus shows the inverse of the last word, so stale data never looks fresh
	always_comb pm_rdata = pm_rd ? psag_word(pm_addr) : ~last_r;
	always @(posedge clock) begin
		if (pm_rd) begin
			last_r <= psag_word(pm_addr);
		end
	end
endmodule

// file: tb_program_space_address_gen.sv
// self-checking testbench for the program space address generator
`timescale 1ns/1ps
module tb_program_space_address_gen;
	logic                   clock, rst_n, reg_wr, reg_rd, acc_valid, tbl_byte_mode;
	logic                   pm_rd, pm_wr, pm_cfg_space, rd_valid, remap_denied;
	logic [3:0]             reg_addr, rev_index, rev_out;
	logic [15:0]            reg_wdata, eff_addr, tbl_wdata, reg_rdata, rd_data;
	logic [22:0]            pc;
	logic [23:0]            pm_rdata, pm_addr, pm_wdata, w;
	logic [2:0]             pm_wmask;
	logic [7:0]             tp;
	psag_pkg::psag_access_t acc_type;
	psag_pkg::psag_tbl_op_t tbl_op;
	int                     bad_count, samples_checked;

	psag_top i_dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.acc_valid, .acc_type, .tbl_op, .tbl_byte_mode, .eff_addr, .tbl_wdata, .pc,
		.rev_index, .pm_rdata, .pm_rd, .pm_wr, .pm_addr, .pm_wdata, .pm_wmask,
		.pm_cfg_space, .rd_valid, .rd_data, .rev_out, .remap_denied);
	psag_pm_model i_mem (.clock, .pm_rd, .pm_addr, .pm_rdata);

	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end

	function automatic logic [23:0] word_at(input logic [23:0] a);
		return {a[7:0] ^ 8'h5A, a[15:0] ^ 16'hC3C3};
	endfunction

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		if (bad_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic reg_wr_t(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'h0;
	endtask

	task automatic reg_rd_t(input logic [3:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'h0;
		#1;
		chk(reg_rdata, e);
	endtask

	task automatic present(input psag_pkg::psag_access_t t, input psag_pkg::psag_tbl_op_t o,
		input logic bm, input logic [15:0] ea);
		@(posedge clock);
		acc_valid <= 1'h1;
		acc_type <= t;
		tbl_op <= o;
		tbl_byte_mode <= bm;
		eff_addr <= ea;
	endtask

	task automatic acc(input psag_pkg::psag_access_t t, input psag_pkg::psag_tbl_op_t o,
		input logic bm, input logic [15:0] ea);
		present(t, o, bm, ea);
		@(posedge clock);
		acc_valid <= 1'h0;
		#1;
	endtask

	task automatic rd_chk(input logic [15:0] e);
		@(posedge clock);
		#1;
		chk(rd_valid, 24'h1);
		chk(rd_data, e);
	endtask

	task automatic tbl_rd(input psag_pkg::psag_tbl_op_t o, input logic bm, input logic [15:0] ea);
		acc(psag_pkg::PSAG_TABLE, o, bm, ea);
		w = word_at({tp, ea});
		chk(pm_rd, 24'h1);
		chk(pm_addr, {tp, ea});
		chk(pm_cfg_space, tp[7]);
	endtask

	task automatic test_regs;
		reg_rd_t(psag_pkg::ADDR_TABLE_PAGE, 16'h0000);
		reg_rd_t(psag_pkg::ADDR_VIS_PAGE, 16'h0000);
		reg_wr_t(psag_pkg::ADDR_VIS_PAGE, 16'h00B7);
		reg_rd_t(psag_pkg::ADDR_VIS_PAGE, 16'h00B7);
		reg_wr_t(4'hF, 16'hFFFF);
		reg_rd_t(4'hF, 16'h0000);
	endtask

	task automatic test_reverse;
		for (int i = 0; i < 16; i++) begin
			@(posedge clock);
			rev_index <= 4'(i);
			@(posedge clock);
			#1;
			chk(rev_out, {i[0], i[1], i[2], i[3]});
		end
	endtask

	task automatic test_table_read;
		tp = 8'h81;
		reg_wr_t(psag_pkg::ADDR_TABLE_PAGE, {8'h00, tp});
		tbl_rd(psag_pkg::PSAG_TBL_READ_LOW, 1'h0, 16'h1235);
		rd_chk(w[15:0]);
		tbl_rd(psag_pkg::PSAG_TBL_READ_LOW, 1'h1, 16'h1235);
		rd_chk({8'h00, w[15:8]});
		tbl_rd(psag_pkg::PSAG_TBL_READ_LOW, 1'h1, 16'h1234);
		rd_chk({8'h00, w[7:0]});
		tbl_rd(psag_pkg::PSAG_TBL_READ_HIGH, 1'h0, 16'h7FFF);
		rd_chk({8'h00, w[23:16]});
		tbl_rd(psag_pkg::PSAG_TBL_READ_HIGH, 1'h1, 16'h0003);
		rd_chk(16'h0000);
		tp = 8'h12;
		reg_wr_t(psag_pkg::ADDR_TABLE_PAGE, {8'h00, tp});
		tbl_rd(psag_pkg::PSAG_TBL_READ_LOW, 1'h0, 16'hFFFE);
		rd_chk(w[15:0]);
	endtask

	task automatic test_fetch;
		@(posedge clock);
		pc <= 23'h5ABCD7;
		acc(psag_pkg::PSAG_FETCH, psag_pkg::PSAG_TBL_READ_LOW, 1'h0, 16'h0000);
		chk(pm_addr, {1'h0, 23'h5ABCD6});
	endtask

	task automatic test_remap;
		reg_wr_t(psag_pkg::ADDR_CORE_CTRL, 16'h0004);
		acc(psag_pkg::PSAG_DATA, psag_pkg::PSAG_TBL_READ_LOW, 1'h0, 16'hF2AB);
		chk(pm_rd, 24'h1);
		chk(pm_wr, 24'h0);
		chk(pm_addr, {1'h0, 8'hB7, 15'h72AA});
		chk(remap_denied, 24'h0);
		rd_chk(16'(word_at({1'h0, 8'hB7, 15'h72AA})));
		reg_rd_t(psag_pkg::ADDR_STATUS, 16'h0004);
		acc(psag_pkg::PSAG_DATA, psag_pkg::PSAG_TBL_READ_LOW, 1'h0, 16'h72AB);
		chk(pm_rd, 24'h0);
		present(psag_pkg::PSAG_TABLE, psag_pkg::PSAG_TBL_READ_LOW, 1'h0, 16'h0010);
		acc(psag_pkg::PSAG_DATA, psag_pkg::PSAG_TBL_READ_LOW, 1'h0, 16'h8002);
		chk(pm_rd, 24'h0);
		chk(remap_denied, 24'h1);
		reg_wr_t(psag_pkg::ADDR_CORE_CTRL, 16'h0000);
		acc(psag_pkg::PSAG_DATA, psag_pkg::PSAG_TBL_READ_LOW, 1'h0, 16'h8002);
		chk(pm_rd, 24'h0);
	endtask

	task automatic test_write;
		@(posedge clock);
		tbl_wdata <= 16'hBEEF;
		acc(psag_pkg::PSAG_TABLE, psag_pkg::PSAG_TBL_WRITE_LOW, 1'h0, 16'h0100);
		chk(pm_wr, 24'h1);
		chk(pm_wmask, 3'h3);
		chk(pm_wdata[15:0], 16'hBEEF);
		acc(psag_pkg::PSAG_TABLE, psag_pkg::PSAG_TBL_WRITE_HIGH, 1'h0, 16'h0100);
		chk(pm_wmask, 3'h4);
		chk(pm_wdata, 24'hEF0000);
		acc(psag_pkg::PSAG_TABLE, psag_pkg::PSAG_TBL_WRITE_LOW, 1'h1, 16'h0101);
		chk(pm_wmask, 3'h2);
		acc(psag_pkg::PSAG_TABLE, psag_pkg::PSAG_TBL_WRITE_HIGH, 1'h1, 16'h0101);
		chk(pm_wmask, 3'h0);
	endtask

	initial begin
		repeat (3000) @(posedge clock);
		bad_count++;
		complete_run;
	end

	initial begin
		{rst_n, reg_wr, reg_rd, acc_valid, tbl_byte_mode} = 5'h00;
		{reg_addr, rev_index, reg_wdata, eff_addr, tbl_wdata, pc} = 79'h0;
		acc_type = psag_pkg::PSAG_FETCH;
		tbl_op = psag_pkg::PSAG_TBL_READ_LOW;
		{bad_count, samples_checked} = 64'h0;
		repeat (2) @(posedge clock);
		rst_n <= 1'h1;
		test_regs;
		test_reverse;
		test_table_read;
		test_fetch;
		test_remap;
		test_write;
		complete_run;
	end
endmodule
